// >>> verilog/adc_serial_params.svh
`ifndef ADC_SERIAL_PARAMS_SVH
`define ADC_SERIAL_PARAMS_SVH

// ----------------------------------------------------------------------
// clocks
// ----------------------------------------------------------------------
`define ADC_REF_CLK_HZ      10000000
`define ADC_SCLK_MIN_HZ     5000
`define ADC_SCLK_MAX_HZ     3000000

// ----------------------------------------------------------------------
// result word layout
// ----------------------------------------------------------------------
`define ADC_MAG_BITS        10
`define ADC_RESULT_BITS     11
`define ADC_SIGN_POS        10
`define ADC_MAG_MSB_TRIAL   10'h200
`define ADC_RESULT_RESET    11'h000

// ----------------------------------------------------------------------
// address word layout and frame timing
// ----------------------------------------------------------------------
`define ADC_ADDR_BITS       4
`define ADC_ADDR_SE_POS     3
`define ADC_CH_BITS         3
`define ADC_ACQ_CYCLES      2
`define ADC_CNT_BITS        4
`define ADC_SYNC_STAGES     2

`endif

// >>> verilog/adc_serial_pkg.sv
`include "adc_serial_params.svh"

package adc_serial_pkg;

   // one-hot frame sequencer states
   typedef enum logic [4:0] {
      ST_ADDR = 5'h01,
      ST_ACQ  = 5'h02,
      ST_SIGN = 5'h04,
      ST_CONV = 5'h08,
      ST_DONE = 5'h10
   } frame_state_t;

   // analog multiplexer steering
   typedef struct packed {
      logic [`ADC_CH_BITS-1:0] pos;
      logic [`ADC_CH_BITS-1:0] neg;
      logic                    neg_com;
   } mux_sel_t;

   typedef logic [`ADC_RESULT_BITS-1:0] result_t;
   typedef logic [`ADC_MAG_BITS-1:0]    magnitude_t;

endpackage

// >>> verilog/adc_link_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// two-flop level synchroniser
// ----------------------------------------------------------------------
module adc_link_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage_one <= '0;
         sync_out  <= '0;
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end

endmodule

`default_nettype wire

// >>> verilog/adc_serial_control_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_serial_params.svh"


module adc_serial_control_port
   import adc_serial_pkg::*;
#(
   parameter int ADDR_BITS  = `ADC_ADDR_BITS,
   parameter int ACQ_CYCLES = `ADC_ACQ_CYCLES
) (
   input  wire logic                     ref_clk,
   input  wire logic                     rst_b,
   input  wire logic                     sclk,
   input  wire logic                     cs_b,
   input  wire logic                     serial_in,
   output var  logic                     serial_out,
   output var  logic                     serial_out_oe_b,
   output var  logic                     conv_busy_flag,
   output var  logic                     conv_busy_oe_b,
   input  wire logic                     power_down_pin,
   output var  logic                     powered_down,
   output var  adc_serial_pkg::mux_sel_t mux_sel,
   output var  logic                     sample_en,
   output var  logic                     sign_trial,
   output var  adc_serial_pkg::magnitude_t sar_trial,
   input  wire logic                     cmp_in,
   output var  adc_serial_pkg::result_t  result_word,
   output var  logic                     result_strobe
);

   import adc_serial_pkg::*;

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------

   // address word to multiplexer steering; single-ended uses common
   function automatic mux_sel_t mux_decode(input logic [ADDR_BITS-1:0] a);
      mux_sel_t m;
      m.pos     = a[`ADC_CH_BITS-1:0];
      m.neg     = {a[`ADC_CH_BITS-1:1], ~a[0]};
      m.neg_com = a[`ADC_ADDR_SE_POS];
      if (a[`ADC_ADDR_SE_POS]) begin
         m.neg = '0;
      end
      return m;
   endfunction

   // one approximation step: keep or drop the trial bit, set the next
   function automatic magnitude_t sar_step(input magnitude_t trial,
                                           input logic [`ADC_CNT_BITS-1:0] idx,
                                           input logic keep);
      magnitude_t t;
      t = trial;
      t[idx] = keep;
      if (idx != '0) begin
         t[idx - 1'b1] = 1'b1;
      end
      return t;
   endfunction

   // ----------------------------------------------------------------
   // link-side declarations
   // ----------------------------------------------------------------
   // last count of the address, acquire and output phases; MAG_LAST is the first count of the conversion
   localparam logic [`ADC_CNT_BITS-1:0] ADDR_LAST =
      `ADC_CNT_BITS'(ADDR_BITS - 1);
   localparam logic [`ADC_CNT_BITS-1:0] ACQ_LAST =
      `ADC_CNT_BITS'(ACQ_CYCLES - 1);
   localparam logic [`ADC_CNT_BITS-1:0] MAG_LAST =
      `ADC_CNT_BITS'(`ADC_MAG_BITS - 1);
   localparam logic [`ADC_CNT_BITS-1:0] OUT_LAST =
      `ADC_CNT_BITS'(`ADC_RESULT_BITS - 1);

   // sequencer, shifters and handover state
   frame_state_t                  state;
   frame_state_t                  next_state;
   logic [`ADC_CNT_BITS-1:0]      bit_cnt;
   logic [`ADC_CNT_BITS-1:0]      next_bit_cnt;
   logic [ADDR_BITS-1:0]          addr_shift;
   logic                          sign_bit;
   result_t                       result_hold;
   logic                          conv_done;
   logic                          result_toggle;
   logic                          pd_link;
   logic [`ADC_CNT_BITS-1:0]      out_idx;
   logic                          out_active;

   // ----------------------------------------------------------------
   // power-down level into the link domain
   // ----------------------------------------------------------------
   adc_link_sync #(
      .WIDTH    (1)
   ) u_pd_link_sync (
      .clk      (sclk),
      .rst_b    (rst_b),
      .async_in (power_down_pin),
      .sync_out (pd_link)
   );

   // ----------------------------------------------------------------
   // frame decode
   // ----------------------------------------------------------------

   // frame runs only with select low and the converter powered
   wire frame_run  = ~cs_b & ~pd_link;
   wire in_addr    = (state == ST_ADDR);
   wire in_acq     = (state == ST_ACQ);
   wire in_sign    = (state == ST_SIGN);
   wire in_conv    = (state == ST_CONV);
   wire addr_last  = in_addr & (bit_cnt == ADDR_LAST);
   wire acq_last   = in_acq & (bit_cnt == ACQ_LAST);
   wire conv_last  = in_conv & (bit_cnt == '0);
   wire addr_load  = frame_run & addr_last;
   wire [ADDR_BITS-1:0] addr_full = {addr_shift[ADDR_BITS-2:0], serial_in};
   wire busy_next  = frame_run & (in_sign | in_conv) & ~conv_last;
   wire magnitude_t trial_next = sar_step(sar_trial, bit_cnt, cmp_in);

   // next state and bit counter of the frame sequencer
   always_comb begin
      next_state   = state;
      next_bit_cnt = bit_cnt;
      case (state)
         ST_ADDR: begin
            next_bit_cnt = bit_cnt + 1'b1;
            if (addr_last) begin
               next_state   = ST_ACQ;
               next_bit_cnt = '0;
            end
         end
         ST_ACQ: begin
            next_bit_cnt = bit_cnt + 1'b1;
            if (acq_last) begin
               next_state   = ST_SIGN;
               next_bit_cnt = MAG_LAST;
            end
         end
         ST_SIGN: begin
            next_state = ST_CONV;
         end
         ST_CONV: begin
            next_bit_cnt = bit_cnt - 1'b1;
            if (conv_last) begin
               next_state   = ST_DONE;
               next_bit_cnt = '0;
            end
         end
         ST_DONE: begin
            next_state = ST_DONE;
         end
         default: begin
            next_state   = ST_ADDR;
            next_bit_cnt = '0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // rising-edge frame logic, cleared whenever select goes high except the result and multiplexer steering
   // ----------------------------------------------------------------

   // sequencer and address shifter
   always_ff @(posedge sclk or negedge rst_b or posedge cs_b) begin
      if (!rst_b) begin
         state      <= ST_ADDR;
         bit_cnt    <= '0;
         addr_shift <= '0;
      end else if (cs_b) begin
         state      <= ST_ADDR;
         bit_cnt    <= '0;
         addr_shift <= '0;
      end else if (frame_run) begin
         state      <= next_state;
         bit_cnt    <= next_bit_cnt;
         if (in_addr) begin
            addr_shift <= addr_full;
         end
      end
   end

   // acquisition, approximation and completion
   always_ff @(posedge sclk or negedge rst_b or posedge cs_b) begin
      if (!rst_b) begin
         sample_en  <= 1'b0;
         sign_bit   <= 1'b0;
         sar_trial  <= '0;
         conv_done  <= 1'b0;
      end else if (cs_b) begin
         sample_en  <= 1'b0;
         sign_bit   <= 1'b0;
         sar_trial  <= '0;
         conv_done  <= 1'b0;
      end else if (frame_run) begin
         sample_en  <= addr_last | (in_acq & ~acq_last);
         if (in_sign) begin
            sign_bit  <= cmp_in;
            sar_trial <= `ADC_MAG_MSB_TRIAL;
         end else if (in_conv) begin
            sar_trial <= trial_next;
         end
         if (conv_last) begin
            conv_done <= 1'b1;
         end
      end
   end

   // sign drives the comparator input swap during the magnitude search
   assign sign_trial = sign_bit;

   // busy flag and its drive; released at once when select rises
   always_ff @(posedge sclk or negedge rst_b or posedge cs_b) begin
      if (!rst_b) begin
         conv_busy_flag <= 1'b0;
         conv_busy_oe_b <= 1'b1;
      end else if (cs_b) begin
         conv_busy_flag <= 1'b0;
         conv_busy_oe_b <= 1'b1;
      end else begin
         conv_busy_flag <= busy_next;
         conv_busy_oe_b <= 1'b0;
      end
   end

   // completed result, kept across frames for the system side
   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         result_hold   <= `ADC_RESULT_RESET;
         result_toggle <= 1'b0;
      end else if (frame_run & conv_last) begin
         result_hold   <= {sign_bit, trial_next};
         result_toggle <= ~result_toggle;
      end
   end

   // multiplexer steering holds until the next address is loaded
   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         mux_sel <= '0;
      end else if (addr_load) begin
         mux_sel <= mux_decode(addr_full);
      end
   end

   // ----------------------------------------------------------------
   // falling-edge result shifter
   // ----------------------------------------------------------------
   // output stage runs once a result is ready
   wire out_go   = ~cs_b & conv_done;
   wire out_more = out_active & (out_idx != OUT_LAST);

   // lsb first, sign last, then low until select rises
   always_ff @(negedge sclk or negedge rst_b or posedge cs_b) begin
      if (!rst_b) begin
         serial_out      <= 1'b0;
         serial_out_oe_b <= 1'b1;
         out_idx         <= '0;
         out_active      <= 1'b0;
      end else if (cs_b) begin
         serial_out      <= 1'b0;
         serial_out_oe_b <= 1'b1;
         out_idx         <= '0;
         out_active      <= 1'b0;
      end else if (out_go) begin
         serial_out_oe_b <= 1'b0;
         out_active      <= 1'b1;
         if (!out_active) begin
            serial_out <= result_hold[0];
         end else if (out_more) begin
            serial_out <= result_hold[out_idx + 1'b1];
            out_idx    <= out_idx + 1'b1;
         end else begin
            serial_out <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // system side on ref_clk
   // ----------------------------------------------------------------
   // system-side copies of link-domain events
   logic pd_ref;
   logic toggle_ref;
   logic toggle_seen;

   // power-down level into the system domain
   adc_link_sync #(
      .WIDTH    (1)
   ) u_pd_ref_sync (
      .clk      (ref_clk),
      .rst_b    (rst_b),
      .async_in (power_down_pin),
      .sync_out (pd_ref)
   );

   // completion toggle into the system domain
   adc_link_sync #(
      .WIDTH    (1)
   ) u_done_sync (
      .clk      (ref_clk),
      .rst_b    (rst_b),
      .async_in (result_toggle),
      .sync_out (toggle_ref)
   );

   // a new result is announced by a change of the toggle
   wire result_new = toggle_ref ^ toggle_seen;

   // power state and result capture; result_hold is stable by then
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         powered_down  <= 1'b0;
         toggle_seen   <= 1'b0;
         result_strobe <= 1'b0;
         result_word   <= `ADC_RESULT_RESET;
      end else begin
         powered_down  <= pd_ref;
         toggle_seen   <= toggle_ref;
         result_strobe <= result_new;
         if (result_new) begin
            result_word <= result_hold;
         end
      end
   end

endmodule

`default_nettype wire

// >>> dv/adc_serial_control_port_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// port checker
// ----------------------------------------------------------------------
module adc_port_checker
   import adc_serial_pkg::*;
#(
   parameter int ADDR_BITS  = 4,
   parameter int ACQ_CYCLES = 2
) (
   input wire logic                     ref_clk,
   input wire logic                     rst_b,
   input wire logic                     sclk,
   input wire logic                     cs_b,
   input wire logic                     serial_out_oe_b,
   input wire logic                     conv_busy_flag,
   input wire logic                     conv_busy_oe_b,
   input wire logic                     power_down_pin,
   input wire logic                     powered_down,
   input wire adc_serial_pkg::mux_sel_t mux_sel,
   input wire logic                     sample_en,
   input wire adc_serial_pkg::result_t  result_word,
   input wire logic                     result_strobe
);
   // ten busy samples, then idle
   sequence busy_run;
      conv_busy_flag [*8] ##1 conv_busy_flag ##1 conv_busy_flag ##1 !conv_busy_flag;
   endsequence

   // system clock side
   ser_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      cs_b |-> serial_out_oe_b) else $error("data out driven while deselected");
   busy_float_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      cs_b |-> conv_busy_oe_b) else $error("busy driven while deselected");
   strobe_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      result_strobe |=> !result_strobe) else $error("strobe longer than a cycle");
   word_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !result_strobe |-> $stable(result_word)) else $error("word moved without strobe");
   pd_enter_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      power_down_pin [*3] |=> powered_down) else $error("power down not taken");
   pd_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !power_down_pin [*3] |=> !powered_down) else $error("power up not taken");

   // link clock side
   mux_load_a: assert property (@(posedge sclk) disable iff (!rst_b)
      !$stable(mux_sel) |-> $rose(sample_en)) else $error("mux moved off load");
   acq_len_a: assert property (@(posedge sclk) disable iff (!rst_b || cs_b)
      $rose(sample_en) |-> ##ACQ_CYCLES !sample_en) else $error("acquire length wrong");
   sign_first_a: assert property (@(posedge sclk) disable iff (!rst_b || cs_b)
      $fell(sample_en) |=> $rose(conv_busy_flag)) else $error("busy late");
   busy_len_a: assert property (@(posedge sclk) disable iff (!rst_b || cs_b)
      $rose(conv_busy_flag) |-> busy_run) else $error("busy length wrong");
   busy_drive_a: assert property (@(posedge sclk) disable iff (!rst_b || cs_b)
      !cs_b |=> !conv_busy_oe_b) else $error("busy not driven while selected");
   out_after_a: assert property (@(posedge sclk) disable iff (!rst_b || cs_b)
      $fell(serial_out_oe_b) |-> $fell(conv_busy_flag)) else $error("out before done");
endmodule

bind adc_serial_control_port adc_port_checker #(
   .ADDR_BITS (ADDR_BITS),
   .ACQ_CYCLES(ACQ_CYCLES)
) chk (
   .ref_clk        (ref_clk),
   .rst_b          (rst_b),
   .sclk           (sclk),
   .cs_b           (cs_b),
   .serial_out_oe_b(serial_out_oe_b),
   .conv_busy_flag (conv_busy_flag),
   .conv_busy_oe_b (conv_busy_oe_b),
   .power_down_pin (power_down_pin),
   .powered_down   (powered_down),
   .mux_sel        (mux_sel),
   .sample_en      (sample_en),
   .result_word    (result_word),
   .result_strobe  (result_strobe)
);

`default_nettype wire

// >>> dv/host_master.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// serial host model
// ----------------------------------------------------------------------
module host_master (
   output var  logic sclk,
   output var  logic cs_b,
   output var  logic serial_in,
   input  wire logic serial_out,
   input  wire logic serial_out_oe_b,
   input  wire logic conv_busy_flag
);
   logic [31:0] busy_seen;
   logic [10:0] bits_seen;

   // clock still, deselected at start
   initial begin
      sclk = 1'b0;
      cs_b = 1'b1;
      serial_in = 1'b0;
   end

   // three idle rises feed the power-down synchroniser, then nr rises
   task automatic frame(input logic [3:0] addr, input int nr);
      int k;
      for (k = 0; k < 3; k++) begin
         #3 sclk = 1'b1;
         #3 sclk = 1'b0;
      end
      cs_b = 1'b0;
      for (k = 1; k <= nr; k++) begin
         serial_in = (k <= 4) ? addr[4-k] : ~serial_in;
         #3 sclk = 1'b1;
         if (k > 17 && k < 29)
            bits_seen[k-18] = serial_out_oe_b ? 1'bx : serial_out;
         #3 sclk = 1'b0;
         busy_seen[k] = conv_busy_flag;
      end
      #3 cs_b = 1'b1;
      serial_in = ~serial_in; // released line does not keep its value
   endtask
endmodule

`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
   import adc_serial_pkg::*;
   logic       ref_clk = 1'b0, rst_b = 1'b1, power_down_pin = 1'b0, sign = 1'b0;
   logic       sclk, cs_b, serial_in, serial_out, serial_out_oe_b, conv_busy_flag, sign_seen;
   logic       conv_busy_oe_b, powered_down, sample_en, sign_trial, result_strobe;
   mux_sel_t   mux_sel;
   magnitude_t sar_trial, mag = 10'h000;
   result_t    result_word, got = 11'h000;
   int         miscompares = 0, num_checks = 0, strobes = 0, cyc = 0, seed_v, i;
   // comparator: sign step before busy, then keep trial bit if not above input
   wire        cmp_in = conv_busy_flag ? (sar_trial <= mag) : sign;

   always #50 ref_clk = ~ref_clk;

   // sign decision as it stands when the magnitude search ends
   always @(negedge conv_busy_flag) sign_seen = sign_trial;

   adc_serial_control_port dut (.ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
      .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_b(serial_out_oe_b),
      .conv_busy_flag(conv_busy_flag), .conv_busy_oe_b(conv_busy_oe_b),
      .power_down_pin(power_down_pin), .powered_down(powered_down), .mux_sel(mux_sel),
      .sample_en(sample_en), .sign_trial(sign_trial), .sar_trial(sar_trial),
      .cmp_in(cmp_in), .result_word(result_word), .result_strobe(result_strobe));

   host_master host (.sclk(sclk), .cs_b(cs_b), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_oe_b(serial_out_oe_b),
      .conv_busy_flag(conv_busy_flag));

   // ------------------------------------------------------------------
   // checking helpers
   // ------------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic results;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // bit 3 single-ended against common, else pair partner is channel xor 1
   function automatic mux_sel_t exp_mux(input logic [3:0] a);
      exp_mux.pos = a[2:0];
      exp_mux.neg = a[3] ? 3'h0 : (a[2:0] ^ 3'h1);
      exp_mux.neg_com = a[3];
   endfunction

   // strobe capture and hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (result_strobe === 1'b1) begin
         strobes++;
         got = result_word;
      end
      if (cyc > 5000) begin
         miscompares++;
         results();
      end
   end

   // one frame of nr rises, full frame is 28 rises
   task automatic conv(input logic [3:0] a, input logic s, input magnitude_t m,
                       input int nr, input logic pd);
      int  n0;
      logic ok;
      sign = s;
      mag = m;
      n0 = strobes;
      ok = (nr == 28) && !pd;
      host.frame(a, nr);
      repeat (8) @(negedge ref_clk);
      check("strobes", 32'(strobes - n0), 32'(ok));
      check("oe", 32'({serial_out_oe_b, conv_busy_oe_b}), 32'h3);
      if (ok) begin
         check("result", 32'(got), 32'({s, m}));
         check("serial", 32'(host.bits_seen), 32'({s, m}));
         check("mux", 32'(mux_sel), 32'(exp_mux(a)));
         check("busy", 32'(host.busy_seen[17:1]), 32'h0FFC0);
         check("sign_trial", 32'(sign_seen), 32'(s));
      end
      $display("test done addr %h nr %0d pd %b", a, nr, pd);
   endtask

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      #1 rst_b = 1'b0;
      repeat (10) @(negedge ref_clk);
      rst_b = 1'b1;
      seed_v = $urandom(95246);
      conv(4'h8, 1'b0, 10'h3FF, 28, 1'b0);
      conv(4'h7, 1'b1, 10'h000, 28, 1'b0);
      conv(4'h5, 1'b1, 10'h155, 10, 1'b0);
      for (i = 0; i < 16; i++)
         conv(4'(i), 1'($urandom), 10'($urandom), 28, 1'b0);
      @(negedge ref_clk);
      power_down_pin = 1'b1;
      repeat (4) @(negedge ref_clk);
      check("powered", 32'(powered_down), 32'h1);
      conv(4'h3, 1'b0, 10'h2AA, 28, 1'b1);
      power_down_pin = 1'b0;
      repeat (4) @(negedge ref_clk);
      check("powered", 32'(powered_down), 32'h0);
      conv(4'hC, 1'b0, 10'h001, 28, 1'b0);
      results();
   end
endmodule

`default_nettype wire
